// [swdc_params.svh]
// Purpose: constants for the configuration-port watchdog block
// Assumes: 40 MHz sys_clk
// Notes:   offsets, field positions, reset values and timing counts
`ifndef SWDC_PARAMS_SVH
`define SWDC_PARAMS_SVH

// ----------------------------------------------------------------
// port addresses and key values
// ----------------------------------------------------------------
`define SWDC_INDEX_ADDR      16'h03f0
`define SWDC_DATA_ADDR       16'h03f1
`define SWDC_UNLOCK_KEY      8'h87
`define SWDC_LOCK_KEY        8'haa

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define SWDC_REG_LDEV        8'h07
`define SWDC_REG_PFSEL_A     8'h2a
`define SWDC_REG_PFSEL_B     8'h2b
`define SWDC_REG_PFSEL_C     8'h2c
`define SWDC_REG_ACTIVATE    8'h30
`define SWDC_REG_PIN12_DEF   8'he2
`define SWDC_REG_PIN13_DEF   8'he3
`define SWDC_REG_PIN16_DEF   8'he6
`define SWDC_REG_WD_COUNT    8'hf2
`define SWDC_REG_WD_EVENT    8'hf3
`define SWDC_REG_WD_UNIT     8'hf4

// ----------------------------------------------------------------
// logical devices, fields and values
// ----------------------------------------------------------------
`define SWDC_LDEV_GPIO       8'h07
`define SWDC_LDEV_WDOG       8'h08
`define SWDC_ACT_ON          8'h01
`define SWDC_PIN_WD_FUNC     8'h0a
`define SWDC_EVENT_ENABLE    8'h0e
`define SWDC_UNIT_SECONDS    8'h40
`define SWDC_PFSEL_A_BIT     7
`define SWDC_PFSEL_B_BIT     0
`define SWDC_PFSEL_C_HI      5
`define SWDC_PFSEL_C_LO      4
`define SWDC_PFSEL_C_PIN16   2'b01
`define SWDC_UNIT_BIT        6
`define SWDC_EVENT_KBD_BIT   2
`define SWDC_EVENT_MOUSE_BIT 3
`define SWDC_EVENT_LED_BIT   1
`define SWDC_RESET_VALUE     8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWDC_CLK_HZ          40000000
`define SWDC_SECOND_S        1
`define SWDC_MINUTE_S        60
`define SWDC_SECOND_CYCLES   (`SWDC_CLK_HZ * `SWDC_SECOND_S)

`endif

// [swdc_pkg.sv]
// Purpose: shared types for the watchdog configuration block
// Assumes: swdc_params.svh holds all numbers
// Notes:   types only
package swdc_pkg;
   typedef logic [7:0]  swdc_byte_t;
   typedef logic [15:0] swdc_addr_t;

   typedef enum logic [1:0]
   {
      SWDC_LOCKED   = 2'b00,
      SWDC_HALF_KEY = 2'b01,
      SWDC_OPEN     = 2'b10
   } swdc_cfg_e;

   typedef enum logic [2:0]
   {
      SWDC_H_IDLE  = 3'b000,
      SWDC_H_KEY1  = 3'b001,
      SWDC_H_KEY2  = 3'b010,
      SWDC_H_INDEX = 3'b011,
      SWDC_H_DATA  = 3'b100,
      SWDC_H_LOCK  = 3'b101,
      SWDC_H_GAP   = 3'b110
   } swdc_host_e;
endpackage : swdc_pkg

// [swdc_io_if.sv]
// Purpose: io port cycle link between host processor and controller
// Assumes: single sys_clk, one access per io_wr/io_rd pulse
// Notes:   read data answers in the cycle after io_rd
`timescale 1ns/10ps
interface swdc_io_if;
   import swdc_pkg::*;
   swdc_addr_t io_addr;
   swdc_byte_t io_wdata;
   logic       io_wr;
   logic       io_rd;
   swdc_byte_t io_rdata;
   logic       io_rvalid;

   modport device
   (
      input  io_addr,
      input  io_wdata,
      input  io_wr,
      input  io_rd,
      output io_rdata,
      output io_rvalid
   );

   modport host
   (
      output io_addr,
      output io_wdata,
      output io_wr,
      output io_rd,
      input  io_rdata,
      input  io_rvalid
   );
endinterface : swdc_io_if

// [swdc_device.sv]
// Purpose: io controller end: configuration port, registers, watchdog
// Assumes: io strobes are one-cycle pulses on sys_clk; kbd/mouse already synchronous
// Notes:   general pins are active-low reset outputs with enables
//
// Functional notes
// - index port 3f0, data port 3f1
// - two 87 writes unlock configuration access
// - aa write relocks configuration access
// - write index first, then data access
// - register 07 selects logical device bank
// - 01 to device 7 reg 30 activates
// - 00 to reg 30 deactivates, no timeout
// - count f2 of device 8, 01 to ff
// - interval follows loaded count value
// - f4 bit 6 picks seconds or minutes
// - f3 0e enables kbd/mouse reload, led
// - e3 0a routes watchdog to pin thirteen
// - 2b bit 0 selects pin thirteen function
// - alternates pin twelve and sixteen routes
// - expiry asserts board reset on pin
`timescale 1ns/10ps
`include "swdc_params.svh"
module swdc_device #(parameter int unsigned SEC_CYC = `SWDC_SECOND_CYCLES)
(
   input  wire logic  sys_clk,
   input  wire logic  rstn,
   swdc_io_if.device  io,
   input  wire logic  kbd_irq,
   input  wire logic  mouse_irq,
   input  wire logic  keyboard_lock_input,
   output logic       keyboard_lock_seen,
   output logic       general_pin_twelve_o,
   output logic       general_pin_twelve_oe_n,
   output logic       general_pin_thirteen_o,
   output logic       general_pin_thirteen_oe_n,
   output logic       general_pin_sixteen_o,
   output logic       general_pin_sixteen_oe_n,
   output logic       power_led,
   output logic       wd_timeout
);
   import swdc_pkg::*;

   localparam int unsigned MIN_SEC = `SWDC_MINUTE_S;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      swdc_cfg_e  cfg;
      swdc_byte_t index;
      swdc_byte_t ldev;
      swdc_byte_t pfsel_a;
      swdc_byte_t pfsel_b;
      swdc_byte_t pfsel_c;
      swdc_byte_t act7;
      swdc_byte_t act8;
      swdc_byte_t pin12;
      swdc_byte_t pin13;
      swdc_byte_t pin16;
      swdc_byte_t wd_count;
      swdc_byte_t wd_event;
      swdc_byte_t wd_unit;
      logic [25:0] tick_cnt;
      logic [5:0]  sec_cnt;
      swdc_byte_t remain;
      logic       expired;
      swdc_byte_t rdata;
      logic       rvalid;
      logic       keyboard_lock_input_s1;
      logic       keyboard_lock_input_s2;
   } swdc_dev_s;

   swdc_dev_s st_reg;
   swdc_dev_s st_next;

   function automatic swdc_byte_t swdc_cfg_read(input swdc_dev_s s);
      swdc_byte_t v;
      v = 8'h00;
      case (s.index)
         `SWDC_REG_LDEV:     v = s.ldev;
         `SWDC_REG_PFSEL_A:  v = s.pfsel_a;
         `SWDC_REG_PFSEL_B:  v = s.pfsel_b;
         `SWDC_REG_PFSEL_C:  v = s.pfsel_c;
         `SWDC_REG_ACTIVATE:
            v = (s.ldev == `SWDC_LDEV_GPIO) ? s.act7 :
                (s.ldev == `SWDC_LDEV_WDOG) ? s.act8 : 8'h00;
         `SWDC_REG_PIN12_DEF: v = (s.ldev == `SWDC_LDEV_GPIO) ? s.pin12 : 8'h00;
         `SWDC_REG_PIN13_DEF: v = (s.ldev == `SWDC_LDEV_GPIO) ? s.pin13 : 8'h00;
         `SWDC_REG_PIN16_DEF: v = (s.ldev == `SWDC_LDEV_GPIO) ? s.pin16 : 8'h00;
         // count reads back the live remaining units
         `SWDC_REG_WD_COUNT: v = (s.ldev == `SWDC_LDEV_WDOG) ? s.remain : 8'h00;
         `SWDC_REG_WD_EVENT: v = (s.ldev == `SWDC_LDEV_WDOG) ? s.wd_event : 8'h00;
         `SWDC_REG_WD_UNIT:  v = (s.ldev == `SWDC_LDEV_WDOG) ? s.wd_unit : 8'h00;
         default:            v = 8'h00;
      endcase
      return v;
   endfunction : swdc_cfg_read

   logic io_idx_wr;
   logic io_dat_wr;
   logic io_dat_rd;
   logic cfg_open;
   logic wd_active;
   logic unit_tick;
   logic kick;

   always_comb
   begin
      st_next   = st_reg;
      io_idx_wr = io.io_wr && (io.io_addr == `SWDC_INDEX_ADDR);
      io_dat_wr = io.io_wr && (io.io_addr == `SWDC_DATA_ADDR);
      io_dat_rd = io.io_rd && (io.io_addr == `SWDC_DATA_ADDR);
      cfg_open  = (st_reg.cfg == SWDC_OPEN);
      wd_active = st_reg.act7[0];
      kick      = 1'b0;

      st_next.keyboard_lock_input_s1 = keyboard_lock_input;
      st_next.keyboard_lock_input_s2 = st_reg.keyboard_lock_input_s1;
      st_next.rvalid    = 1'b0;

      // ----------------------------------------------------------------
      // unlock key sequence on the index port
      // ----------------------------------------------------------------
      if (io_idx_wr)
      begin
         case (st_reg.cfg)
            SWDC_LOCKED:
               st_next.cfg = (io.io_wdata == `SWDC_UNLOCK_KEY) ? SWDC_HALF_KEY
                                                                : SWDC_LOCKED;
            SWDC_HALF_KEY:
               st_next.cfg = (io.io_wdata == `SWDC_UNLOCK_KEY) ? SWDC_OPEN
                                                                : SWDC_LOCKED;
            SWDC_OPEN:
               if (io.io_wdata == `SWDC_LOCK_KEY)
                  st_next.cfg = SWDC_LOCKED;
               else
                  st_next.index = io.io_wdata;
            default:
               st_next.cfg = SWDC_LOCKED;
         endcase
      end

      // ----------------------------------------------------------------
      // data port; writes ignored and reads answer ff while locked
      // ----------------------------------------------------------------
      if (io_dat_rd)
      begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = cfg_open ? swdc_cfg_read(st_reg) : 8'hff;
      end

      if (io_dat_wr && cfg_open)
      begin
         case (st_reg.index)
            `SWDC_REG_LDEV:    st_next.ldev    = io.io_wdata;
            `SWDC_REG_PFSEL_A: st_next.pfsel_a = io.io_wdata;
            `SWDC_REG_PFSEL_B: st_next.pfsel_b = io.io_wdata;
            `SWDC_REG_PFSEL_C: st_next.pfsel_c = io.io_wdata;
            `SWDC_REG_ACTIVATE:
               if (st_reg.ldev == `SWDC_LDEV_GPIO)
                  st_next.act7 = io.io_wdata;
               else if (st_reg.ldev == `SWDC_LDEV_WDOG)
                  st_next.act8 = io.io_wdata;
            `SWDC_REG_PIN12_DEF:
               if (st_reg.ldev == `SWDC_LDEV_GPIO) st_next.pin12 = io.io_wdata;
            `SWDC_REG_PIN13_DEF:
               if (st_reg.ldev == `SWDC_LDEV_GPIO) st_next.pin13 = io.io_wdata;
            `SWDC_REG_PIN16_DEF:
               if (st_reg.ldev == `SWDC_LDEV_GPIO) st_next.pin16 = io.io_wdata;
            `SWDC_REG_WD_COUNT:
               if (st_reg.ldev == `SWDC_LDEV_WDOG)
               begin
                  st_next.wd_count = io.io_wdata;
                  kick = (io.io_wdata != 8'h00);
               end
            `SWDC_REG_WD_EVENT:
               if (st_reg.ldev == `SWDC_LDEV_WDOG) st_next.wd_event = io.io_wdata;
            `SWDC_REG_WD_UNIT:
               if (st_reg.ldev == `SWDC_LDEV_WDOG) st_next.wd_unit = io.io_wdata;
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // count engine
      // ----------------------------------------------------------------
      if ((kbd_irq && st_reg.wd_event[`SWDC_EVENT_KBD_BIT]) ||
          (mouse_irq && st_reg.wd_event[`SWDC_EVENT_MOUSE_BIT]))
         kick = kick || (st_reg.wd_count != 8'h00);

      // one second of sys_clk cycles, then sixty of those for a minute
      unit_tick = 1'b0;
      if (!wd_active || kick)
      begin
         st_next.tick_cnt = '0;
         st_next.sec_cnt  = '0;
      end
      else if (st_reg.tick_cnt == 26'(SEC_CYC - 1))
      begin
         st_next.tick_cnt = '0;
         if (st_reg.wd_unit[`SWDC_UNIT_BIT] ||
             (st_reg.sec_cnt == 6'(MIN_SEC - 1)))
         begin
            st_next.sec_cnt = '0;
            unit_tick = 1'b1;
         end
         else
            st_next.sec_cnt = st_reg.sec_cnt + 6'd1;
      end
      else
         st_next.tick_cnt = st_reg.tick_cnt + 26'd1;

      if (!wd_active)
      begin
         st_next.expired = 1'b0;
         st_next.remain  = st_reg.wd_count;
      end
      else if (kick)
      begin
         st_next.remain  = (io_dat_wr && cfg_open &&
                            st_reg.index == `SWDC_REG_WD_COUNT) ? io.io_wdata
                                                                : st_reg.wd_count;
         st_next.expired = 1'b0;
      end
      else if (unit_tick && st_reg.remain != 8'h00)
      begin
         st_next.remain = st_reg.remain - 8'd1;
         if (st_reg.remain == 8'h01)
            st_next.expired = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // ----------------------------------------------------------------
   // outputs and pin routing
   // ----------------------------------------------------------------
   logic route12;
   logic route13;
   logic route16;

   always_comb
   begin
      route12 = st_reg.pfsel_a[`SWDC_PFSEL_A_BIT] &&
                (st_reg.pin12 == `SWDC_PIN_WD_FUNC);
      route13 = st_reg.pfsel_b[`SWDC_PFSEL_B_BIT] &&
                (st_reg.pin13 == `SWDC_PIN_WD_FUNC);
      route16 = (st_reg.pfsel_c[`SWDC_PFSEL_C_HI:`SWDC_PFSEL_C_LO] ==
                 `SWDC_PFSEL_C_PIN16) && (st_reg.pin16 == `SWDC_PIN_WD_FUNC);
   end

   // active-low board reset driven low only while expired
   assign general_pin_twelve_o      = 1'b0;
   assign general_pin_twelve_oe_n   = !(route12 && st_reg.expired);
   assign general_pin_thirteen_o    = 1'b0;
   assign general_pin_thirteen_oe_n = !(route13 && st_reg.expired);
   assign general_pin_sixteen_o     = 1'b0;
   assign general_pin_sixteen_oe_n  = !(route16 && st_reg.expired);
   assign keyboard_lock_seen        = !st_reg.pfsel_b[`SWDC_PFSEL_B_BIT] && st_reg.keyboard_lock_input_s2;
   assign power_led                 = st_reg.expired && st_reg.wd_event[`SWDC_EVENT_LED_BIT];
   assign wd_timeout                = st_reg.expired;
   assign io.io_rdata               = st_reg.rdata;
   assign io.io_rvalid              = st_reg.rvalid;
endmodule : swdc_device

// [swdc_host.sv]
// Purpose: host end: turns register requests into indexed port cycles
// Assumes: one request at a time, taken while req_ready is high
// Notes:   every request unlocks, accesses and relocks
`timescale 1ns/10ps
`include "swdc_params.svh"
module swdc_host
(
   input  wire logic  sys_clk,
   input  wire logic  rstn,
   swdc_io_if.host    io,
   input  wire logic  req_valid,
   input  wire logic  req_write,
   input  wire logic [7:0] req_index,
   input  wire logic [7:0] req_wdata,
   output logic       req_ready,
   output logic [7:0] rsp_rdata,
   output logic       rsp_valid
);
   import swdc_pkg::*;

   typedef struct packed
   {
      swdc_host_e st;
      logic       write;
      swdc_byte_t index;
      swdc_byte_t wdata;
      swdc_addr_t addr;
      swdc_byte_t odata;
      logic       wr;
      logic       rd;
      swdc_byte_t rdata;
      logic       rvalid;
   } swdc_host_s;

   swdc_host_s h_reg;
   swdc_host_s h_next;

   always_comb
   begin
      h_next        = h_reg;
      h_next.wr     = 1'b0;
      h_next.rd     = 1'b0;
      h_next.rvalid = 1'b0;
      case (h_reg.st)
         SWDC_H_IDLE:
            if (req_valid)
            begin
               h_next.write = req_write;
               h_next.index = req_index;
               h_next.wdata = req_wdata;
               h_next.addr  = `SWDC_INDEX_ADDR;
               h_next.odata = `SWDC_UNLOCK_KEY;
               h_next.wr    = 1'b1;
               h_next.st    = SWDC_H_KEY1;
            end
         SWDC_H_KEY1:
         begin
            h_next.odata = `SWDC_UNLOCK_KEY;
            h_next.wr    = 1'b1;
            h_next.st    = SWDC_H_KEY2;
         end
         SWDC_H_KEY2:
         begin
            h_next.odata = h_reg.index;
            h_next.wr    = 1'b1;
            h_next.st    = SWDC_H_INDEX;
         end
         SWDC_H_INDEX:
         begin
            h_next.addr  = `SWDC_DATA_ADDR;
            h_next.odata = h_reg.wdata;
            h_next.wr    = h_reg.write;
            h_next.rd    = !h_reg.write;
            h_next.st    = SWDC_H_DATA;
         end
         SWDC_H_DATA:
            if (h_reg.write || io.io_rvalid)
            begin
               h_next.rdata  = io.io_rdata;
               h_next.addr   = `SWDC_INDEX_ADDR;
               h_next.odata  = `SWDC_LOCK_KEY;
               h_next.wr     = 1'b1;
               h_next.st     = SWDC_H_LOCK;
            end
         SWDC_H_LOCK:
         begin
            h_next.rvalid = 1'b1;
            h_next.st     = SWDC_H_GAP;
         end
         SWDC_H_GAP:
            h_next.st = SWDC_H_IDLE;
         default:
            h_next.st = SWDC_H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         h_reg <= '0;
      else
         h_reg <= h_next;
   end

   assign io.io_addr  = h_reg.addr;
   assign io.io_wdata = h_reg.odata;
   assign io.io_wr    = h_reg.wr;
   assign io.io_rd    = h_reg.rd;
   assign req_ready   = (h_reg.st == SWDC_H_IDLE);
   assign rsp_rdata   = h_reg.rdata;
   assign rsp_valid   = h_reg.rvalid;
endmodule : swdc_host

// [swdc_properties.sv]
// Purpose: io port cycle checks between host end and device end
// Assumes: one sys_clk domain, rstn async active low
// Notes:   only index values other than the two key bytes are used
`timescale 1ns/10ps
`include "swdc_params.svh"
module swdc_properties
(
   input wire logic                sys_clk,
   input wire logic                rstn,
   input wire swdc_pkg::swdc_addr_t io_addr,
   input wire swdc_pkg::swdc_byte_t io_wdata,
   input wire logic                io_wr,
   input wire logic                io_rd,
   input wire swdc_pkg::swdc_byte_t io_rdata,
   input wire logic                io_rvalid
);
   import swdc_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // port cycle relations
   // ----------------------------------------------------------------
   chk_rvalid_after_rd: assert property (io_rd && io_addr == `SWDC_DATA_ADDR |=> io_rvalid)
      else $error("no read answer after data port read");
   chk_rvalid_has_cause: assert property (io_rvalid |-> $past(io_rd))
      else $error("read answer without a read");
   chk_rvalid_one_cycle: assert property (io_rvalid |=> !io_rvalid)
      else $error("read answer longer than one cycle");
   chk_strobes_exclusive: assert property (!(io_wr && io_rd))
      else $error("write and read strobe together");
   chk_key_then_index: assert property ((io_wr && io_addr == `SWDC_INDEX_ADDR
      && io_wdata == `SWDC_UNLOCK_KEY) ##1 (io_wr && io_addr == `SWDC_INDEX_ADDR
      && io_wdata == `SWDC_UNLOCK_KEY) |=> io_wr && io_addr == `SWDC_INDEX_ADDR)
      else $error("index write does not follow the unlock keys");
   chk_index_then_data: assert property (io_wr && io_addr == `SWDC_INDEX_ADDR
      && io_wdata != `SWDC_UNLOCK_KEY && io_wdata != `SWDC_LOCK_KEY
      |=> (io_wr || io_rd) && io_addr == `SWDC_DATA_ADDR)
      else $error("data access does not follow index");
   chk_write_relock: assert property (io_wr && io_addr == `SWDC_DATA_ADDR |=> io_wr
      && io_addr == `SWDC_INDEX_ADDR && io_wdata == `SWDC_LOCK_KEY)
      else $error("no relock after data write");
   chk_read_relock: assert property (io_rd && io_addr == `SWDC_DATA_ADDR |=> !io_wr ##1
      (io_wr && io_addr == `SWDC_INDEX_ADDR && io_wdata == `SWDC_LOCK_KEY))
      else $error("no relock after data read");
   chk_gap_after_relock: assert property (io_wr && io_wdata == `SWDC_LOCK_KEY
      && io_addr == `SWDC_INDEX_ADDR |=> (!io_wr && !io_rd) [*2])
      else $error("port cycle too soon after relock");
endmodule : swdc_properties

// [superio_watchdog_config_tb.sv]
// Purpose: host end and device end joined, driven from the request side
// Assumes: a 32-cycle second brings expiry within a few thousand cycles
// Notes:   read results checked through a queue of expected values
`timescale 1ns/10ps
`include "swdc_params.svh"
module superio_watchdog_config_tb;
   import swdc_pkg::*;
   logic       sys_clk, rstn, req_valid, req_write, req_ready, rsp_valid;
   logic [7:0] req_index, req_wdata, rsp_rdata, v;
   logic       kbd_irq, mouse_irq, keyboard_lock_input, keyboard_lock_seen, wd_timeout;
   logic       power_led, p12_oe_n, p13_oe_n, p16_oe_n;
   logic       chk_q[$];
   logic [7:0] exp_q[$];
   int         n_mismatch, n_tests, seed, i;
   logic [7:0] r_idx[9] = '{8'h2a, 8'h2b, 8'h2c, 8'he2, 8'he3, 8'he6, 8'hf3, 8'hf4, 8'h07};
   logic [7:0] r_dev[9] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h08, 8'h08, 8'h08};
   swdc_io_if io_link ();
   swdc_host i_swdc_host (.sys_clk(sys_clk), .rstn(rstn), .io(io_link.host),
      .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_rdata(rsp_rdata),
      .rsp_valid(rsp_valid));
   swdc_device #(.SEC_CYC(32)) i_swdc_device (.sys_clk(sys_clk), .rstn(rstn),
      .io(io_link.device),
      .kbd_irq(kbd_irq), .mouse_irq(mouse_irq), .keyboard_lock_input(keyboard_lock_input),
      .keyboard_lock_seen(keyboard_lock_seen), .general_pin_twelve_o(),
      .general_pin_twelve_oe_n(p12_oe_n), .general_pin_thirteen_o(),
      .general_pin_thirteen_oe_n(p13_oe_n), .general_pin_sixteen_o(),
      .general_pin_sixteen_oe_n(p16_oe_n), .power_led(power_led), .wd_timeout(wd_timeout));
   swdc_properties i_swdc_properties (.sys_clk(sys_clk), .rstn(rstn),
      .io_addr(io_link.io_addr), .io_wdata(io_link.io_wdata), .io_wr(io_link.io_wr),
      .io_rd(io_link.io_rd), .io_rdata(io_link.io_rdata), .io_rvalid(io_link.io_rvalid));
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------------------------------
   // checking and requests
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic req(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic chk, input logic [7:0] exp);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 50)
      begin
         @(posedge sys_clk);
         #2;
         n++;
      end
      if (req_ready !== 1'b1)
      begin
         check("request ready", 8'h00, 8'h01);
         results();
      end
      req_valid = 1'b1;
      req_write = w;
      req_index = idx;
      req_wdata = d;
      chk_q.push_back(chk);
      exp_q.push_back(exp);
      @(posedge sys_clk);
      #2;
      req_valid = 1'b0;
   endtask : req
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      req(1'b1, idx, d, 1'b0, 8'h00);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      req(1'b0, idx, 8'h00, 1'b1, exp);
   endtask : rd
   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 50)
      begin
         @(posedge sys_clk);
         #2;
         n++;
      end
      if (exp_q.size() != 0)
      begin
         check("pending responses", 8'(exp_q.size()), 8'h00);
         results();
      end
   endtask : drain
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   always @(posedge sys_clk)
   begin
      if (rstn && rsp_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected response", 8'h01, 8'h00);
         else
         begin
            if (chk_q.pop_front())
               check("read data", rsp_rdata, exp_q.pop_front());
            else
               void'(exp_q.pop_front());
         end
      end
   end
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      n_mismatch++;
      $display("run did not finish in time");
      results();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      seed = 32'h29b9d598;
      {rstn, req_valid, req_write, kbd_irq, mouse_irq, keyboard_lock_input} = 6'h00;
      req_index = 8'h00;
      req_wdata = 8'h00;
      repeat (10) @(posedge sys_clk);
      #2;
      rstn = 1'b1;
      wr(8'h07, 8'h08);
      rd(8'h07, 8'h08);
      rd(8'hf2, 8'h00);
      rd(8'hf4, 8'h00);
      wr(8'h07, 8'h07);
      rd(8'h30, 8'h00);
      rd(8'he3, 8'h00);
      drain();
      $display("test reset_values done");
      // first eight table fields (not 07) written with a random byte and read back in their own bank
      for (i = 0; i < 8; i++)
      begin
         v = 8'($random(seed));
         wr(8'h07, r_dev[i]);
         wr(r_idx[i], v);
         rd(r_idx[i], v);
      end
      rd(8'he3, 8'h00);
      drain();
      $display("test readback done");
      wr(8'h07, 8'h07);
      wr(8'he3, 8'h0a);
      wr(8'h2b, 8'h00);
      drain();
      keyboard_lock_input = 1'($random(seed));
      repeat (4) @(posedge sys_clk);
      #2;
      check("keyboard lock seen", {7'h00, keyboard_lock_seen}, {7'h00, keyboard_lock_input});
      keyboard_lock_input = 1'b1;
      wr(8'h2b, 8'h01);
      wr(8'h2a, 8'h80);
      wr(8'he2, 8'h0a);
      wr(8'h2c, 8'h10);
      wr(8'he6, 8'h0a);
      drain();
      check("pin thirteen idle", {7'h00, p13_oe_n}, 8'h01);
      check("pin twelve idle", {7'h00, p12_oe_n}, 8'h01);
      check("pin sixteen idle", {7'h00, p16_oe_n}, 8'h01);
      check("keyboard lock masked", {7'h00, keyboard_lock_seen}, 8'h00);
      $display("test pin_route done");
      wr(8'h30, 8'h01);
      wr(8'h07, 8'h08);
      wr(8'hf4, 8'h40);
      wr(8'hf3, 8'h0e);
      wr(8'hf2, 8'h05);
      rd(8'hf2, 8'h05);
      drain();
      kbd_irq = 1'b1;
      mouse_irq = 1'b1;
      @(posedge sys_clk);
      #2;
      {kbd_irq, mouse_irq} = 2'b00;
      rd(8'hf2, 8'h05);
      wr(8'hf2, 8'hff);
      rd(8'hf2, 8'hff);
      // two units of 32 cycles: expiry lands 64 cycles after the count write
      wr(8'hf2, 8'h02);
      drain();
      repeat (60) @(posedge sys_clk);
      #2;
      check("timeout early", {7'h00, wd_timeout}, 8'h00);
      repeat (4) @(posedge sys_clk);
      #2;
      check("timeout due", {7'h00, wd_timeout}, 8'h01);
      check("pin thirteen reset", {7'h00, p13_oe_n}, 8'h00);
      check("pin twelve reset", {7'h00, p12_oe_n}, 8'h00);
      check("pin sixteen reset", {7'h00, p16_oe_n}, 8'h00);
      check("power led on", {7'h00, power_led}, 8'h01);
      rd(8'hf2, 8'h00);
      // one minute unit is sixty 32-cycle seconds
      wr(8'hf4, 8'h00);
      wr(8'hf2, 8'h01);
      drain();
      repeat (1900) @(posedge sys_clk);
      #2;
      check("minute early", {7'h00, wd_timeout}, 8'h00);
      repeat (30) @(posedge sys_clk);
      #2;
      check("minute due", {7'h00, wd_timeout}, 8'h01);
      $display("test expiry done");
      wr(8'h07, 8'h07);
      wr(8'h30, 8'h00);
      rd(8'h30, 8'h00);
      drain();
      check("timeout level", {7'h00, wd_timeout}, 8'h00);
      check("power led", {7'h00, power_led}, 8'h00);
      $display("test timer_control done");
      results();
   end
endmodule : superio_watchdog_config_tb
